// ---- src/exec_unit_cfg.svh ----
// constants for the transfer/string/arithmetic execution unit
// assumes: included by bare name from the unit's module and the testbench
`ifndef EXEC_UNIT_CFG_SVH
`define EXEC_UNIT_CFG_SVH

// ============================================================
// register port offsets (byte addresses, one word each)
`define REG_SRC_ADDR    8'h00
`define REG_DST_ADDR    8'h04
`define REG_COUNT       8'h08
`define REG_FILL        8'h0C
`define REG_STATUS      8'h10

// ============================================================
// status word fields and flag vector positions
`define STAT_BUSY       0
`define STAT_OVF        1
`define FLAG_C          0
`define FLAG_Z          1
`define FLAG_S          2
`define FLAG_O          3

// ============================================================
// reset values and arithmetic constants
`define RST_WORD16      16'h0000
`define RST_WORD32      32'h0000_0000
`define STEP_BYTE       16'h0001
`define STEP_WORD       16'h0002
`define BCD_MAX_DIGIT   5'h09
`define BCD_ADJUST      5'h06
`define QUO_MAX_S8      34'sh0_0000_007F
`define QUO_MIN_S8      -34'sh0_0000_0080
`define QUO_MAX_U8      34'sh0_0000_00FF
`define QUO_MAX_S16     34'sh0_0000_7FFF
`define QUO_MIN_S16     -34'sh0_0000_8000
`define QUO_MAX_U16     34'sh0_0000_FFFF

`endif

// ---- src/exec_unit_pkg.sv ----
// types for the transfer/string/arithmetic execution unit
// assumes: the decoder sends one op_e code per accepted operation
package exec_unit_pkg;

    typedef enum logic [4:0] {
        nibble_upper_to_upper,
        nibble_upper_to_lower,
        nibble_lower_to_upper,
        nibble_lower_to_lower,
        store_if_zero,
        store_if_not_zero,
        two_way_cond_store,
        string_copy_forward,
        string_copy_backward,
        string_fill,
        signed_product,
        unsigned_product,
        signed_quotient_trunc,
        signed_quotient_floor,
        unsigned_quotient,
        bcd_sum,
        bcd_sum_with_carry,
        bcd_difference,
        bcd_difference_with_borrow
    } op_e;

    typedef enum logic [2:0] {
        st_idle,
        st_exec,
        st_read,
        st_write,
        st_done
    } state_e;

endpackage : exec_unit_pkg

// ---- src/transfer_arith_exec_unit.sv ----
// execution datapath: nibble moves, conditional stores, string copy and fill,
// multiply, divide and packed-decimal add/subtract
// assumes: decoder holds operands with op_valid; memory answers a read one cycle later
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "exec_unit_cfg.svh"

module transfer_arith_exec_unit
    import exec_unit_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        op_valid,
    output logic             op_ready,
    input  wire op_e         op_code,
    input  wire logic        op_word,
    input  wire logic [15:0] src_a,
    input  wire logic [7:0]  src_b,
    input  wire logic [31:0] dest_in,
    input  wire logic [3:0]  flags_in,
    output logic             result_valid,
    output logic             result_we,
    output logic [31:0]      result_data,
    output logic [3:0]       flags_out,
    output logic             mem_rd,
    output logic             mem_wr,
    output logic             mem_word,
    output logic [15:0]      mem_addr,
    output logic [15:0]      mem_wdata,
    input  wire logic [15:0] mem_rdata,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata
);

    // ============================================================
    // arithmetic helpers
    function automatic logic [16:0] bcd_calc(input logic [15:0] a, input logic [15:0] b,
                                             input logic cin, input logic sub, input logic word);
        logic [4:0]  d;
        logic        cy;
        logic        cb;
        logic [15:0] r;
        cy = cin;
        cb = 1'b0;
        r  = `RST_WORD16;
        for (int i = 0; i < 4; i++) begin
            if (sub) begin
                d  = {1'b0, a[i*4+:4]} - {1'b0, b[i*4+:4]} - {4'h0, cy};
                cy = d[4];
                if (cy) d = d - `BCD_ADJUST;
            end else begin
                d  = {1'b0, a[i*4+:4]} + {1'b0, b[i*4+:4]} + {4'h0, cy};
                cy = (d > `BCD_MAX_DIGIT);
                if (cy) d = d + `BCD_ADJUST;
            end
            r[i*4+:4] = d[3:0];
            if (i == 1) cb = cy;
        end
        return word ? {cy, r} : {cb, 8'h00, r[7:0]};
    endfunction : bcd_calc

    // returns {overflow, remainder, quotient}
    function automatic logic [32:0] div_calc(input logic [31:0] dvd, input logic [15:0] dvs,
                                             input logic sgn, input logic flr, input logic word);
        logic signed [33:0] n;
        logic signed [33:0] d;
        logic signed [33:0] q;
        logic signed [33:0] r;
        logic signed [33:0] hi;
        logic signed [33:0] lo;
        n  = word ? (sgn ? {{2{dvd[31]}}, dvd} : {2'b00, dvd})
                  : (sgn ? {{18{dvd[15]}}, dvd[15:0]} : {18'h00000, dvd[15:0]});
        d  = word ? (sgn ? {{18{dvs[15]}}, dvs} : {18'h00000, dvs})
                  : (sgn ? {{26{dvs[7]}}, dvs[7:0]} : {26'h0000000, dvs[7:0]});
        hi = word ? (sgn ? `QUO_MAX_S16 : `QUO_MAX_U16) : (sgn ? `QUO_MAX_S8 : `QUO_MAX_U8);
        lo = sgn ? (word ? `QUO_MIN_S16 : `QUO_MIN_S8) : 34'sh0;
        if (d == 34'sh0) return {1'b1, `RST_WORD32};
        q = n / d;
        r = n % d;
        if (flr && r != 34'sh0 && (r[33] != d[33])) begin
            q = q - 34'sh1;
            r = r + d;
        end
        if (q > hi || q < lo) return {1'b1, `RST_WORD32};
        return word ? {1'b0, r[15:0], q[15:0]} : {1'b0, 16'h0000, r[7:0], q[7:0]};
    endfunction : div_calc

    // ============================================================
    // state and registers
    state_e      state_r;
    state_e      state_nxt;
    op_e         op_r;
    logic        word_r;
    logic [3:0]  flags_in_r;
    logic [15:0] src_addr_r;
    logic [15:0] dst_addr_r;
    logic [15:0] count_r;
    logic [15:0] fill_r;
    logic        ovf_seen_r;
    logic        result_valid_r;
    logic        result_we_r;
    logic [31:0] result_data_r;
    logic [3:0]  flags_out_r;
    logic [31:0] reg_rdata_r;

    // ============================================================
    // decode
    wire         accept     = op_valid && op_ready;
    wire         is_string  = (op_code == string_copy_forward) || (op_code == string_copy_backward)
                              || (op_code == string_fill);
    wire         is_mul     = (op_code == signed_product) || (op_code == unsigned_product);
    wire         is_div     = (op_code == signed_quotient_trunc) || (op_code == signed_quotient_floor)
                              || (op_code == unsigned_quotient);
    wire         is_sub     = (op_code == bcd_difference) || (op_code == bcd_difference_with_borrow);
    wire         use_cin    = (op_code == bcd_sum_with_carry) || (op_code == bcd_difference_with_borrow);
    wire         zf         = flags_in[`FLAG_Z];
    wire [15:0]  step       = word_r ? `STEP_WORD : `STEP_BYTE;
    wire         last_elem  = (count_r == `STEP_BYTE);
    wire         fill_op    = (op_r == string_fill);
    wire         back_op    = (op_r == string_copy_backward);

    // ============================================================
    // combinational results for one-cycle operations
    wire [7:0]   nib_src    = src_a[7:0];
    wire [7:0]   nib_dst    = dest_in[7:0];
    wire [31:0]  prod_s     = op_word ? 32'($signed(src_a) * $signed(dest_in[15:0]))
                                      : {16'h0000, 16'($signed(src_a[7:0]) * $signed(dest_in[7:0]))};
    wire [31:0]  prod_u     = op_word ? 32'(src_a * dest_in[15:0])
                                      : {16'h0000, 16'(src_a[7:0] * dest_in[7:0])};
    wire [32:0]  div_res    = div_calc(dest_in, src_a, op_code != unsigned_quotient,
                                       op_code == signed_quotient_floor, op_word);
    wire         bcd_cin    = use_cin && (is_sub ? !flags_in[`FLAG_C] : flags_in[`FLAG_C]);
    wire [16:0]  bcd_res    = bcd_calc(dest_in[15:0], src_a, bcd_cin, is_sub, op_word);
    wire         bcd_sign   = op_word ? bcd_res[15] : bcd_res[7];
    wire         bcd_zero   = (bcd_res[15:0] == `RST_WORD16);

    logic [31:0] exec_data;
    logic        exec_we;
    logic [3:0]  exec_flags;

    always_comb begin
        exec_data  = dest_in;
        exec_we    = 1'b1;
        exec_flags = flags_in;
        case (op_code)
            nibble_upper_to_upper: exec_data[7:0] = {nib_src[7:4], nib_dst[3:0]};
            nibble_upper_to_lower: exec_data[7:0] = {nib_dst[7:4], nib_src[7:4]};
            nibble_lower_to_upper: exec_data[7:0] = {nib_src[3:0], nib_dst[3:0]};
            nibble_lower_to_lower: exec_data[7:0] = {nib_dst[7:4], nib_src[3:0]};
            store_if_zero: begin
                exec_data[7:0] = src_a[7:0];
                exec_we        = zf;
            end
            store_if_not_zero: begin
                exec_data[7:0] = src_a[7:0];
                exec_we        = !zf;
            end
            two_way_cond_store: exec_data[7:0] = zf ? src_a[7:0] : src_b;
            signed_product:   exec_data = prod_s;
            unsigned_product: exec_data = prod_u;
            signed_quotient_trunc, signed_quotient_floor, unsigned_quotient: begin
                exec_data             = div_res[31:0];
                exec_we               = !div_res[32];
                exec_flags[`FLAG_O]   = div_res[32];
            end
            bcd_sum, bcd_sum_with_carry, bcd_difference, bcd_difference_with_borrow: begin
                exec_data           = {16'h0000, bcd_res[15:0]};
                exec_flags[`FLAG_S] = bcd_sign;
                exec_flags[`FLAG_Z] = bcd_zero;
                exec_flags[`FLAG_C] = is_sub ? !bcd_res[16] : bcd_res[16];
            end
            default: exec_we = 1'b0;
        endcase
    end

    // ============================================================
    // sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            st_idle: begin
                if (accept && is_string)
                    state_nxt = (count_r == `RST_WORD16) ? st_done
                              : (op_code == string_fill) ? st_write : st_read;
                else if (accept)
                    state_nxt = st_exec;
            end
            st_exec:  state_nxt = st_idle;
            st_read:  state_nxt = st_write;
            st_write: state_nxt = last_elem ? st_done : (fill_op ? st_write : st_read);
            st_done:  state_nxt = st_idle;
            default:  state_nxt = st_idle;
        endcase
    end

    assign op_ready  = (state_r == st_idle);
    assign mem_rd    = (state_r == st_read);
    assign mem_wr    = (state_r == st_write);
    assign mem_word  = word_r;
    assign mem_addr  = mem_rd ? src_addr_r : dst_addr_r;
    assign mem_wdata = fill_op ? fill_r : mem_rdata;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_r    <= st_idle;
            op_r       <= nibble_upper_to_upper;
            word_r     <= 1'b0;
            flags_in_r <= 4'h0;
        end else begin
            state_r <= state_nxt;
            if (accept) begin
                op_r       <= op_code;
                word_r     <= op_word;
                flags_in_r <= flags_in;
            end
        end
    end

    // ============================================================
    // pointers, count and fill value; the string engine owns them while busy
    wire bus_wr_ok = reg_wr && op_ready;
    wire sel_src   = (reg_addr == `REG_SRC_ADDR);
    wire sel_dst   = (reg_addr == `REG_DST_ADDR);
    wire sel_count = (reg_addr == `REG_COUNT);
    wire sel_fill  = (reg_addr == `REG_FILL);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            src_addr_r <= `RST_WORD16;
            dst_addr_r <= `RST_WORD16;
            count_r    <= `RST_WORD16;
            fill_r     <= `RST_WORD16;
        end else if (mem_wr) begin
            dst_addr_r <= back_op ? dst_addr_r - step : dst_addr_r + step;
            src_addr_r <= back_op ? src_addr_r - step : src_addr_r + step;
            count_r    <= count_r - `STEP_BYTE;
        end else if (bus_wr_ok) begin
            if (sel_src)   src_addr_r <= reg_wdata[15:0];
            if (sel_dst)   dst_addr_r <= reg_wdata[15:0];
            if (sel_count) count_r    <= reg_wdata[15:0];
            if (sel_fill)  fill_r     <= reg_wdata[15:0];
        end
    end

    // ============================================================
    // results and register reads
    wire [31:0] status_word = {30'h0, ovf_seen_r, !op_ready};
    wire [31:0] rd_mux = sel_src   ? {16'h0000, src_addr_r}
                       : sel_dst   ? {16'h0000, dst_addr_r}
                       : sel_count ? {16'h0000, count_r}
                       : sel_fill  ? {16'h0000, fill_r}
                       : (reg_addr == `REG_STATUS)   ? status_word : `RST_WORD32;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            result_valid_r <= 1'b0;
            result_we_r    <= 1'b0;
            result_data_r  <= `RST_WORD32;
            flags_out_r    <= 4'h0;
            ovf_seen_r     <= 1'b0;
            reg_rdata_r    <= `RST_WORD32;
        end else begin
            result_valid_r <= (accept && !is_string) || (state_r == st_done) && 1'b1;
            result_we_r    <= accept && !is_string && exec_we;
            if (accept && !is_string) begin
                result_data_r <= exec_data;
                flags_out_r   <= exec_flags;
                ovf_seen_r    <= is_div ? div_res[32] : ovf_seen_r;
            end else if (state_r == st_done) begin
                flags_out_r   <= flags_in_r;
            end
            reg_rdata_r <= reg_rd ? rd_mux : `RST_WORD32;
        end
    end

    assign result_valid = result_valid_r;
    assign result_we    = result_we_r;
    assign result_data  = result_data_r;
    assign flags_out    = flags_out_r;
    assign reg_rdata    = reg_rdata_r;

    // ============================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    chk_nibble_merge: assert property (accept && op_code == nibble_lower_to_upper |=>
        result_data[7:0] == {$past(src_a[3:0]), $past(dest_in[3:0])})
        else $error("nibble merge wrong");

    chk_stz_hold: assert property (accept && op_code == store_if_zero && !zf |=>
        result_valid && !result_we)
        else $error("store_if_zero wrote with zero flag clear");

    chk_store_if_not_zero_hold: assert property (accept && op_code == store_if_not_zero |=>
        result_we == !$past(zf))
        else $error("store_if_not_zero write enable wrong");

    chk_two_way_pick: assert property (accept && op_code == two_way_cond_store |=>
        result_we && result_data[7:0] == ($past(zf) ? $past(src_a[7:0]) : $past(src_b)))
        else $error("two-way store picked wrong source");

    chk_copy_fwd_step: assert property (mem_wr && op_r == string_copy_forward |=>
        src_addr_r == $past(src_addr_r) + $past(step))
        else $error("forward copy source did not step up");

    chk_copy_bwd_step: assert property (mem_wr && back_op |=>
        dst_addr_r == $past(dst_addr_r) - $past(step))
        else $error("backward copy destination did not step down");

    chk_mul_flags_kept: assert property (accept && is_mul |=>
        flags_out == $past(flags_in))
        else $error("multiply changed flags");

    chk_mul_word_value: assert property (accept && op_code == unsigned_product && op_word |=>
        result_data == $past(src_a) * $past(dest_in[15:0]))
        else $error("word product wrong");

    chk_div_other_flags: assert property (accept && is_div |=>
        flags_out[2:0] == $past(flags_in[2:0]))
        else $error("divide changed a flag other than overflow");

    chk_div_zero_guard: assert property (accept && is_div && src_a == 16'h0000 |=>
        flags_out[`FLAG_O] && !result_we)
        else $error("divide by zero not flagged");

    chk_string_done: assert property (mem_wr && last_elem |->
        ##1 state_r == st_done ##1 result_valid)
        else $error("string op did not finish after last element");

    chk_fill_value: assert property (mem_wr && fill_op |-> mem_wdata == fill_r)
        else $error("fill wrote a value other than the held one");

    chk_bcd_zero_flag: assert property (accept && op_code == bcd_sum |=>
        flags_out[`FLAG_Z] == (result_data[15:0] == `RST_WORD16))
        else $error("decimal zero flag disagrees with result");

    cov_fill_run:  cover property (mem_wr && fill_op ##1 mem_wr ##2 result_valid);
    cov_div_ovf:   cover property (accept && is_div && src_a != 16'h0000 ##1 flags_out[`FLAG_O]);
    cov_bcd_carry: cover property (accept && op_code == bcd_sum_with_carry ##1 flags_out[`FLAG_C]);
    cov_copy_back: cover property (mem_wr && back_op ##1 mem_rd);
    cov_div_floor: cover property (accept && op_code == signed_quotient_floor);

endmodule : transfer_arith_exec_unit

`default_nettype wire

// ---- verification/exec_mem_model.sv ----
// byte-wide data memory on the far side of the unit's string port
// assumes: read data due in the cycle after mem_rd; writes land at the edge
`timescale 1ns/1ns
`default_nettype none

module exec_mem_model (
    input  wire logic        clock,
    input  wire logic        mem_rd,
    input  wire logic        mem_wr,
    input  wire logic        mem_word,
    input  wire logic [15:0] mem_addr,
    input  wire logic [15:0] mem_wdata,
    output logic      [15:0] mem_rdata
);
    logic [7:0] mem [0:255];
    logic [7:0] lo_a;
    logic [7:0] hi_a;

    assign lo_a = mem_addr[7:0];
    assign hi_a = lo_a + 8'h01;

    initial mem_rdata = 16'h5A5A;

    // ============================================================
    // read answers one cycle later; an idle bus never repeats old data
    always @(posedge clock) begin
        if (mem_rd) begin
            mem_rdata <= {mem_word ? mem[hi_a] : ~mem[lo_a], mem[lo_a]};
        end else begin
            mem_rdata <= ~mem_rdata;
        end
        if (mem_wr) begin
            mem[lo_a] <= mem_wdata[7:0];
            if (mem_word) begin
                mem[hi_a] <= mem_wdata[15:8];
            end
        end
    end
endmodule : exec_mem_model

`default_nettype wire

// ---- verification/transfer_arith_exec_unit_tb_top.sv ----
// self-checking bench for the transfer/string/arithmetic execution unit
// assumes: exec_mem_model stands as data memory; one 25 MHz clock
`timescale 1ns/1ns
`default_nettype none
`include "exec_unit_cfg.svh"

module transfer_arith_exec_unit_tb_top
    import exec_unit_pkg::*;
;
    logic        clock, arst_n, op_valid, op_word, reg_wr, reg_rd;
    op_e         op_code;
    logic [15:0] src_a, mem_addr, mem_wdata, mem_rdata;
    logic [7:0]  src_b, reg_addr;
    logic [31:0] dest_in, reg_wdata, reg_rdata, result_data;
    logic [3:0]  flags_in, flags_out;
    logic        op_ready, result_valid, result_we, mem_rd, mem_wr, mem_word;
    int          err_count, checks;

    transfer_arith_exec_unit i_transfer_arith_exec_unit (.clock, .arst_n, .op_valid, .op_ready, .op_code,
        .op_word, .src_a, .src_b, .dest_in, .flags_in, .result_valid, .result_we, .result_data, .flags_out,
        .mem_rd, .mem_wr, .mem_word, .mem_addr, .mem_wdata, .mem_rdata, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata);
    exec_mem_model i_exec_mem_model (.clock, .mem_rd, .mem_wr, .mem_word, .mem_addr, .mem_wdata, .mem_rdata);

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // ============================================================
    // compares, verdict and bus tasks
    task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp_data

    task automatic cmp_flags(input logic [3:0] got, input logic [3:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t %s flags %b exp %b", $time, what, got, exp);
        end
    endtask : cmp_flags

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    // issue one operation, return at the negedge where result_valid stands
    task automatic run_op(input op_e c, input logic w, input logic [15:0] a, input logic [7:0] b,
                          input logic [31:0] d, input logic [3:0] f);
        int n;
        @(posedge clock);
        {op_valid, op_word, src_a, src_b, dest_in, flags_in} <= {1'b1, w, a, b, d, f};
        op_code <= c;
        n = 0;
        do begin @(negedge clock); n++; end while (op_ready !== 1'b1 && n < 300);
        @(posedge clock);
        op_valid <= 1'b0;
        do begin @(negedge clock); n++; end while (result_valid !== 1'b1 && n < 300);
        if (n >= 300) begin
            err_count++;
            $display("FAIL %0t operation timed out", $time);
            complete_run();
        end
    endtask : run_op

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_check(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clock);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        cmp_data(reg_rdata, exp, what);
    endtask : reg_check

    // one checked operation: write enable, masked data and flags
    task automatic op_case(input op_e c, input logic w, input logic [15:0] a, input logic [7:0] b,
                           input logic [31:0] d, input logic [3:0] f, input logic we, input logic [31:0] m,
                           input logic [31:0] exp, input logic [3:0] ef);
        run_op(c, w, a, b, d, f);
        cmp_data({31'h0000_0000, result_we}, {31'h0000_0000, we}, c.name());
        if (we) cmp_data(result_data & m, exp, c.name());
        cmp_flags(flags_out, ef, c.name());
    endtask : op_case

    // ============================================================
    // scenarios
    task automatic test_moves;
        op_case(nibble_upper_to_upper, 0, 16'h00A5, 0, 32'h1234_563C, 5, 1, '1, 32'h1234_56AC, 5);
        op_case(nibble_upper_to_lower, 0, 16'h00A5, 0, 32'h1234_563C, 5, 1, '1, 32'h1234_563A, 5);
        op_case(nibble_lower_to_upper, 0, 16'h00A5, 0, 32'h1234_563C, 5, 1, '1, 32'h1234_565C, 5);
        op_case(nibble_lower_to_lower, 0, 16'h00A5, 0, 32'h1234_563C, 5, 1, '1, 32'h1234_5635, 5);
        op_case(store_if_zero, 0, 16'h0077, 8'h99, 32'hCAFE_0011, 4'h2, 1, '1, 32'hCAFE_0077, 4'h2);
        op_case(store_if_zero, 0, 16'h0077, 8'h99, 32'hCAFE_0011, 4'h0, 0, '1, 0, 4'h0);
        op_case(store_if_not_zero, 0, 16'h0077, 8'h99, 32'hCAFE_0011, 4'h0, 1, '1, 32'hCAFE_0077, 0);
        op_case(store_if_not_zero, 0, 16'h0077, 8'h99, 32'hCAFE_0011, 4'h2, 0, '1, 0, 4'h2);
        op_case(two_way_cond_store, 0, 16'h0077, 8'h99, 32'hCAFE_0011, 4'h2, 1, '1, 32'hCAFE_0077, 2);
        op_case(two_way_cond_store, 0, 16'h0077, 8'h99, 32'hCAFE_0011, 4'h0, 1, '1, 32'hCAFE_0099, 0);
        $display("test moves done");
    endtask : test_moves

    task automatic test_mul;
        op_case(signed_product, 0, 16'h003F, 0, 32'h14, 4'hF, 1, 32'hFFFF, 32'h04EC, 4'hF);
        op_case(signed_product, 0, 16'h00FE, 0, 32'h03, 4'h0, 1, 32'hFFFF, 32'hFFFA, 4'h0);
        op_case(unsigned_product, 0, 16'h00FE, 0, 32'h03, 4'hA, 1, 32'hFFFF, 32'h02FA, 4'hA);
        op_case(signed_product, 1, 16'h03E8, 0, 32'h016D, 4'h5, 1, '1, 32'h0005_91C8, 4'h5);
        op_case(signed_product, 1, 16'hFFFE, 0, 32'h0003, 4'h5, 1, '1, 32'hFFFF_FFFA, 4'h5);
        op_case(unsigned_product, 1, 16'hFFFF, 0, 32'hFFFF, 4'h5, 1, '1, 32'hFFFE_0001, 4'h5);
        $display("test multiply done");
    endtask : test_mul

    task automatic test_div;
        op_case(signed_quotient_trunc, 0, 16'h00FC, 0, 32'h21, 4'hF, 1, 32'hFFFF, 32'h01F8, 4'h7);
        op_case(signed_quotient_trunc, 0, 16'h0004, 0, 32'hFFDF, 4'h7, 1, 32'hFFFF, 32'hFFF8, 4'h7);
        op_case(signed_quotient_floor, 0, 16'h00FC, 0, 32'h21, 4'h7, 1, 32'hFFFF, 32'hFDF7, 4'h7);
        op_case(signed_quotient_floor, 0, 16'h0004, 0, 32'hFFDF, 4'h7, 1, 32'hFFFF, 32'h03F7, 4'h7);
        op_case(unsigned_quotient, 0, 16'h0007, 0, 32'h00C8, 4'h7, 1, 32'hFFFF, 32'h041C, 4'h7);
        op_case(signed_quotient_trunc, 1, 16'h0004, 0, 32'hFFFF_FFDF, 4'h7, 1, '1, 32'hFFFF_FFF8, 7);
        op_case(unsigned_quotient, 1, 16'h0007, 0, 32'h0001_86A0, 4'h0, 1, '1, 32'h0005_37CD, 4'h0);
        op_case(unsigned_quotient, 0, 16'h0000, 0, 32'h0064, 4'h7, 0, '1, 0, 4'hF);
        op_case(unsigned_quotient, 0, 16'h0001, 0, 32'h1000, 4'h0, 0, '1, 0, 4'h8);
        reg_check(`REG_STATUS, 32'h0000_0002, "status");
        $display("test divide done");
    endtask : test_div

    task automatic test_bcd;
        op_case(bcd_sum, 0, 16'h0028, 0, 32'h19, 4'h1, 1, 32'hFF, 32'h47, 4'h0);
        op_case(bcd_sum_with_carry, 0, 16'h0001, 0, 32'h99, 4'h1, 1, 32'hFF, 32'h01, 4'h1);
        op_case(bcd_sum, 0, 16'h0050, 0, 32'h50, 4'h0, 1, 32'hFF, 32'h00, 4'h3);
        op_case(bcd_sum, 1, 16'h1234, 0, 32'h8766, 4'h0, 1, 32'hFFFF, 32'h0000, 4'h3);
        op_case(bcd_difference, 0, 16'h0017, 0, 32'h42, 4'h0, 1, 32'hFF, 32'h25, 4'h1);
        op_case(bcd_difference_with_borrow, 0, 16'h0010, 0, 32'h10, 4'h0, 1, 32'hFF, 32'h99, 4'h4);
        op_case(bcd_difference_with_borrow, 1, 16'h0001, 0, 32'h1000, 4'h1, 1, 32'hFFFF, 32'h0999, 1);
        $display("test decimal done");
    endtask : test_bcd

    task automatic test_string;
        int i;
        for (i = 0; i < 256; i++) i_exec_mem_model.mem[i] = 8'h00;
        for (i = 0; i < 4; i++) i_exec_mem_model.mem[8'h20 + i] = 8'h11 * (i + 1);
        reg_write(`REG_SRC_ADDR, 32'h20);
        reg_write(`REG_DST_ADDR, 32'h40);
        reg_write(`REG_COUNT, 32'h2);
        op_case(string_copy_forward, 1, 0, 0, 0, 4'hA, 0, '1, 0, 4'hA);
        for (i = 0; i < 4; i++) cmp_data(i_exec_mem_model.mem[8'h40 + i], 8'h11 * (i + 1), "fwd copy");
        reg_check(`REG_SRC_ADDR, 32'h24, "fwd src");
        reg_check(`REG_DST_ADDR, 32'h44, "fwd dst");
        reg_write(`REG_SRC_ADDR, 32'h21);
        reg_write(`REG_DST_ADDR, 32'h51);
        reg_write(`REG_COUNT, 32'h2);
        op_case(string_copy_backward, 0, 0, 0, 0, 4'h5, 0, '1, 0, 4'h5);
        cmp_data(i_exec_mem_model.mem[8'h50], 8'h11, "back copy");
        cmp_data(i_exec_mem_model.mem[8'h51], 8'h22, "back copy");
        reg_check(`REG_SRC_ADDR, 32'h1F, "back src");
        reg_write(`REG_DST_ADDR, 32'h60);
        reg_write(`REG_COUNT, 32'h3);
        reg_write(`REG_FILL, 32'h5A);
        op_case(string_fill, 0, 0, 0, 0, 4'h3, 0, '1, 0, 4'h3);
        for (i = 0; i < 4; i++) cmp_data(i_exec_mem_model.mem[8'h60 + i], i < 3 ? 8'h5A : 8'h00, "fill");
        reg_check(`REG_DST_ADDR, 32'h63, "fill dst");
        reg_check(8'h40, 32'h0, "unmapped");
        $display("test string done");
    endtask : test_string

    initial begin
        {arst_n, op_valid, op_word, reg_wr, reg_rd} = '0;
        {src_a, src_b, dest_in, flags_in, reg_addr, reg_wdata} = '0;
        op_code = nibble_upper_to_upper;
        err_count = 0;
        checks = 0;
        repeat (4) @(posedge clock);
        arst_n <= 1'b1;
        test_moves();
        test_mul();
        test_div();
        test_bcd();
        test_string();
        complete_run();
    end
endmodule : transfer_arith_exec_unit_tb_top

`default_nettype wire
